// ===== logic/ssp_pkg.sv
// Shared constants and types for the sensor two-wire slave port
`default_nettype none
package ssp_pkg;
	// Three-level address pin codes as seen at the pin inputs
	localparam logic [1:0] PIN_LOW       = 2'h0;
	localparam logic [1:0] PIN_HIGH      = 2'h1;
	localparam logic [1:0] PIN_FLOAT     = 2'h2;
	// Upper four address bits shared by every strap choice
	localparam logic [3:0] ADDR_BASE     = 4'h9;
	// Low three address bits per strap combination (pin b, pin a)
	localparam logic [2:0] ADR_LO_LO     = 3'h0;
	localparam logic [2:0] ADR_LO_FL     = 3'h1;
	localparam logic [2:0] ADR_LO_HI     = 3'h2;
	localparam logic [2:0] ADR_FL_LO     = 3'h3;
	localparam logic [2:0] ADR_HI_LO     = 3'h4;
	localparam logic [2:0] ADR_HI_FL     = 3'h5;
	localparam logic [2:0] ADR_HI_HI     = 3'h6;
	localparam logic [2:0] ADR_FL_HI     = 3'h7;
	// Bus protocol constants
	localparam logic [6:0] GC_ADDR       = 7'h00;
	localparam logic [7:0] ARA_BYTE      = 8'h19;
	localparam logic [7:0] GC_CMD_LATCH  = 8'h04;
	localparam logic [7:0] GC_CMD_RESET  = 8'h06;
	localparam logic [4:0] HS_CODE_TOP   = 5'h01;
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam logic [7:0] PTR_RST       = 8'h00;
	// Synchroniser reset level: bus lines idle high, straps low
	localparam logic [5:0] SYNC_IDLE     = 6'h30;
	// Cycles after reset or request before the address pins are captured
	localparam logic [1:0] LATCH_DLY     = 2'h3;
	localparam logic [1:0] LATCH_TAKE    = 2'h1;
	// Byte index handling inside one transfer
	localparam logic [1:0] IDX_FIRST     = 2'h0;
	localparam logic [1:0] IDX_TOP       = 2'h3;
	localparam logic [1:0] IDX_WRAP      = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ACK  = 3'h2,
		ST_RX   = 3'h3,
		ST_TX   = 3'h4,
		ST_MACK = 3'h5
	} ssp_state_e;

	typedef enum logic [1:0] {
		K_WR  = 2'h0,
		K_RD  = 2'h1,
		K_GC  = 2'h2,
		K_ARA = 2'h3
	} ssp_kind_e;
endpackage
`default_nettype wire

// ===== logic/ssp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0 // Reset level, the idle level of each line
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	if (W < 1)
	begin : g_chk
		$error("ssp_sync width must be at least one");
	end

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= RST;
			q      <= RST;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== logic/ssp_addr_map.sv
// Strap decode from three-level pins to a seven-bit slave address
`timescale 1ns/1ps
`default_nettype none
module ssp_addr_map
	import ssp_pkg::*;
#(
	parameter int TWO_PIN = 1
) (
	input  wire logic [1:0] pin_a,
	input  wire logic [1:0] pin_b,
	output var  logic [6:0] addr
);
	logic [2:0] low;

	if (TWO_PIN != 0 && TWO_PIN != 1)
	begin : g_chk
		$error("TWO_PIN must be 0 or 1");
	end

	// Low bits from the strap levels; single pin variant ignores pin b
	always_comb
	begin
		low = ADR_LO_LO;
		if (TWO_PIN == 1)
		begin
			case ({pin_b, pin_a})
				{PIN_LOW, PIN_FLOAT}:   low = ADR_LO_FL;
				{PIN_LOW, PIN_HIGH}:    low = ADR_LO_HI;
				{PIN_HIGH, PIN_LOW}:    low = ADR_HI_LO;
				{PIN_HIGH, PIN_FLOAT}:  low = ADR_HI_FL;
				{PIN_HIGH, PIN_HIGH}:   low = ADR_HI_HI;
				{PIN_FLOAT, PIN_LOW}:   low = ADR_FL_LO;
				{PIN_FLOAT, PIN_HIGH}:  low = ADR_FL_HI;
				{PIN_FLOAT, PIN_FLOAT}: low = ADR_FL_LO; // Unlisted strap
				default:                low = ADR_LO_LO;
			endcase
		end
		else if (pin_a == PIN_FLOAT)
			low = ADR_LO_FL;
		else if (pin_a == PIN_HIGH)
			low = ADR_LO_HI;
		addr = {ADDR_BASE, low};
	end
endmodule
`default_nettype wire

// ===== logic/ssp_i2c_slave.sv
// Two-wire slave port of the temperature sensor
//
// Behaviour
// - Two-pin variant maps two three-level straps onto eight addresses 1001000..1001111.
// - Single-pin variant uses 1001000 low, 1001001 floating, 1001010 high.
// - Straps are captured after reset or on request, then held latched.
// - Master makes the clock, START and STOP; this port only responds.
// - Address byte is seven address bits then a direction bit, shifted by all.
// - On own address match, SDA is pulled low through the ninth clock.
// - Each byte takes eight clocks plus one acknowledge from the receiver.
// - SDA change while SCL high is taken as START or STOP.
// - First byte after a write address loads the pointer.
// - Reads use the last written pointer; pointer-only writes are accepted.
// - As receiver, acknowledge address, pointer and data; data goes to pointed register.
// - As transmitter, send pointed register high byte first, then low byte.
// - NACK, START or STOP from master ends the read; port releases SDA.
// - In interrupt mode the flag pin serves as the alert line.
// - Alert response address is acknowledged while alert active, then own address returned.
// - Returned last bit: low for upper, high for lower event, inverted by sense.
// - Lost arbitration keeps alert; a won response clears it at completion.
// - Variant without alert pin still answers alert response in interrupt mode.
// - General Call address with write direction is acknowledged; next byte is a command.
// - Command 00000100 re-captures the straps and resets nothing else.
// - Command 00000110 re-captures the straps and resets internal registers.
// - Every byte moves most significant bit first.
// - Interrupt-mode alert clears on register read, won response or shutdown.
// - General Call reset clears alert and returns core to comparator mode.
// - High-speed master code is not acknowledged but selects fast filters until STOP.
`timescale 1ns/1ps
`default_nettype none
module ssp_i2c_slave
	import ssp_pkg::*;
#(
	parameter int TWO_PIN = 1
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output var  logic        sda_o,
	output var  logic        sda_oe,
	input  wire logic [1:0]  addr_select_pin_a,
	input  wire logic [1:0]  addr_select_pin_b,
	input  wire logic        interrupt_mode_sel,
	input  wire logic        output_sense_sel,
	input  wire logic        alert_active,
	input  wire logic        alert_dir_low,
	input  wire logic        shutdown_en,
	input  wire logic [15:0] reg_rd_data,
	output var  logic [7:0]  reg_ptr,
	output var  logic        reg_wr_stb,
	output var  logic [7:0]  reg_wr_data,
	output var  logic        reg_wr_lsb,
	output var  logic        reg_rd_stb,
	output var  logic        alert_clear,
	output var  logic        gc_reset,
	output var  logic        alert_pin,
	output var  logic        hs_mode,
	output var  logic [6:0]  slave_addr
);
	ssp_state_e  state_q;
	ssp_kind_e   kind_q;
	logic [2:0]  bit_cnt_q;
	logic [7:0]  shift_q;
	logic [1:0]  idx_q;
	logic [1:0]  latch_cnt_q;
	logic        scl_p_q;
	logic        sda_p_q;
	logic        sd_p_q;
	logic        scl_s;
	logic        sda_s;
	logic [1:0]  pin_a_s;
	logic [1:0]  pin_b_s;
	logic [6:0]  map_addr;
	logic [7:0]  rx_byte;
	logic [7:0]  tx_byte;
	logic [1:0]  idx_inc;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        byte_end;
	logic        addr_done;
	logic        rx_done;
	logic        own_hit;
	logic        gc_hit;
	logic        ara_hit;
	logic        hs_hit;
	logic        ara_win;
	logic        latch_req;

	// Bring the bus lines and straps into the clock domain
	ssp_sync #(.W(6), .RST(SYNC_IDLE)) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.d       ({scl_i, sda_i, addr_select_pin_b, addr_select_pin_a}),
		.q       ({scl_s, sda_s, pin_b_s, pin_a_s})
	);

	ssp_addr_map #(.TWO_PIN(TWO_PIN)) u_map (
		.pin_a (pin_a_s),
		.pin_b (pin_b_s),
		.addr  (map_addr)
	);

	// Previous samples for edge and condition detection
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			sd_p_q  <= 1'b0;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			sd_p_q  <= shutdown_en;
		end
	end

	// Bus events and byte decode
	assign scl_rise  = scl_s && !scl_p_q;
	assign scl_fall  = !scl_s && scl_p_q;
	assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_det  = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign rx_byte   = {shift_q[6:0], sda_s};
	assign byte_end  = scl_rise && bit_cnt_q == BIT_LAST;
	assign addr_done = state_q == ST_ADDR && byte_end;
	assign rx_done   = state_q == ST_RX && byte_end;
	assign own_hit   = rx_byte[7:1] == slave_addr;
	assign gc_hit    = rx_byte[7:1] == GC_ADDR && !rx_byte[0];
	assign ara_hit   = rx_byte == ARA_BYTE && interrupt_mode_sel && alert_active;
	assign hs_hit    = rx_byte[7:3] == HS_CODE_TOP;
	assign ara_win   = state_q == ST_MACK && scl_rise && kind_q == K_ARA;
	assign idx_inc   = (idx_q == IDX_TOP) ? IDX_WRAP : idx_q + 2'h1;
	assign latch_req = rx_done && kind_q == K_GC && idx_q == IDX_FIRST &&
		(rx_byte == GC_CMD_LATCH || rx_byte == GC_CMD_RESET);

	// Byte to send: own address with event bit, or pointed register half
	always_comb
	begin
		tx_byte = reg_rd_data[15:8];
		if (kind_q == K_ARA)
			tx_byte = {slave_addr, alert_dir_low ^ output_sense_sel};
		else if (idx_q[0])
			tx_byte = reg_rd_data[7:0];
	end

	// Transfer sequencer: address, acknowledge, receive, transmit
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q   <= ST_IDLE;
			kind_q    <= K_WR;
			bit_cnt_q <= 3'h0;
			shift_q   <= 8'h00;
			idx_q     <= IDX_FIRST;
			sda_oe    <= 1'b0;
		end
		else if (start_det)
		begin
			state_q   <= ST_ADDR;
			bit_cnt_q <= 3'h0;
			idx_q     <= IDX_FIRST;
			sda_oe    <= 1'b0;
		end
		else if (stop_det)
		begin
			state_q <= ST_IDLE;
			sda_oe  <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
				end
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						shift_q   <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 3'h1;
					end
					if (addr_done)
					begin
						if (own_hit)
						begin
							state_q <= ST_ACK;
							kind_q  <= rx_byte[0] ? K_RD : K_WR;
						end
						else if (gc_hit)
						begin
							state_q <= ST_ACK;
							kind_q  <= K_GC;
						end
						else if (ara_hit)
						begin
							state_q <= ST_ACK;
							kind_q  <= K_ARA;
						end
						else
							state_q <= ST_IDLE;
					end
				end
				ST_ACK:
				begin
					if (scl_fall && !sda_oe)
						sda_oe <= 1'b1;
					else if (scl_fall && (kind_q == K_RD || kind_q == K_ARA))
					begin
						shift_q <= tx_byte;
						sda_oe  <= !tx_byte[7];
						state_q <= ST_TX;
					end
					else if (scl_fall)
					begin
						sda_oe  <= 1'b0;
						state_q <= ST_RX;
					end
				end
				ST_RX:
				begin
					if (scl_rise)
					begin
						shift_q   <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 3'h1;
					end
					if (rx_done)
					begin
						state_q <= ST_ACK;
						idx_q   <= idx_inc;
					end
				end
				ST_TX:
				begin
					if (scl_fall)
						sda_oe <= !shift_q[7];
					if (scl_rise && !sda_oe && !sda_s && kind_q == K_ARA)
						state_q <= ST_IDLE;
					else if (scl_rise)
					begin
						shift_q   <= {shift_q[6:0], 1'b1};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == BIT_LAST)
						begin
							state_q <= ST_MACK;
							idx_q   <= idx_inc;
						end
					end
				end
				ST_MACK:
				begin
					if (scl_fall)
						sda_oe <= 1'b0;
					if (scl_rise && !sda_s && kind_q == K_RD)
					begin
						shift_q <= tx_byte;
						state_q <= ST_TX;
					end
					else if (scl_rise)
						state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Pointer load from the first byte of a write; held across reads
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_ptr <= PTR_RST;
		else if (latch_req && rx_byte == GC_CMD_RESET)
			reg_ptr <= PTR_RST;
		else if (rx_done && kind_q == K_WR && idx_q == IDX_FIRST)
			reg_ptr <= rx_byte;
	end

	// Data byte strobe toward the pointed register
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_wr_stb  <= 1'b0;
			reg_wr_data <= 8'h00;
			reg_wr_lsb  <= 1'b0;
		end
		else
		begin
			reg_wr_stb <= rx_done && kind_q == K_WR && idx_q != IDX_FIRST;
			if (rx_done)
			begin
				reg_wr_data <= rx_byte;
				reg_wr_lsb  <= !idx_q[0];
			end
		end
	end

	// Read, alert clear and General Call reset pulses
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rd_stb  <= 1'b0;
			alert_clear <= 1'b0;
			gc_reset    <= 1'b0;
		end
		else
		begin
			reg_rd_stb  <= addr_done && own_hit && rx_byte[0];
			gc_reset    <= latch_req && rx_byte == GC_CMD_RESET;
			alert_clear <= (addr_done && own_hit && rx_byte[0] && interrupt_mode_sel) ||
				ara_win || (shutdown_en && !sd_p_q && interrupt_mode_sel) ||
				(latch_req && rx_byte == GC_CMD_RESET);
		end
	end

	// Fast filter select after a master code, back to normal on STOP
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			hs_mode <= 1'b0;
		else if (stop_det)
			hs_mode <= 1'b0;
		else if (addr_done && hs_hit)
			hs_mode <= 1'b1;
	end

	// Strap capture: counts down after reset or command, then holds
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			latch_cnt_q <= LATCH_DLY;
			slave_addr  <= {ADDR_BASE, ADR_LO_LO};
		end
		else if (latch_req)
			latch_cnt_q <= LATCH_DLY;
		else if (latch_cnt_q != 2'h0)
		begin
			latch_cnt_q <= latch_cnt_q - 2'h1;
			if (latch_cnt_q == LATCH_TAKE)
				slave_addr <= map_addr;
		end
	end

	// Alert line level, active low unless sense is set; held high when pin absent
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alert_pin <= 1'b1;
			sda_o     <= 1'b0;
		end
		else
		begin
			alert_pin <= (TWO_PIN == 1) ? 1'b1 : (alert_active ~^ output_sense_sel);
			sda_o     <= 1'b0;
		end
	end

	// Checks on the sequencer and its side effects
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	addr_ack_a: assert property (addr_done && own_hit && !start_det && !stop_det
		|=> state_q == ST_ACK && !sda_oe) else $error("own address not taken");
	foreign_drop_a: assert property (addr_done && !own_hit && !gc_hit && !ara_hit &&
		!start_det && !stop_det |=> state_q == ST_IDLE && !sda_oe)
		else $error("foreign address answered");
	stop_release_a: assert property (stop_det |=> !sda_oe && state_q == ST_IDLE)
		else $error("SDA held after STOP");
	ptr_load_a: assert property (rx_done && kind_q == K_WR && idx_q == IDX_FIRST && !latch_req
		|=> reg_ptr == $past(rx_byte)) else $error("pointer not loaded");
	ptr_keep_a: assert property (state_q == ST_TX && !latch_req |=> $stable(reg_ptr))
		else $error("pointer moved during read");
	wr_stb_a: assert property (reg_wr_stb |-> $past(kind_q) == K_WR && $past(idx_q) != IDX_FIRST)
		else $error("data strobe outside write data");
	msb_drive_a: assert property (state_q == ST_TX && scl_fall && !start_det && !stop_det
		|=> sda_oe == !$past(shift_q[7])) else $error("wrong bit driven");
	ara_bit_a: assert property (state_q == ST_ACK && kind_q == K_ARA && scl_fall && sda_oe
		&& !start_det && !stop_det |=> shift_q[0] == $past(alert_dir_low ^ output_sense_sel))
		else $error("alert event bit wrong");
	gc_latch_a: assert property (latch_req |=> ##2 latch_cnt_q == LATCH_TAKE)
		else $error("strap capture not restarted");
	hs_set_a: assert property (addr_done && hs_hit && !own_hit && !gc_hit && !ara_hit
		&& !stop_det |=> hs_mode && state_q == ST_IDLE) else $error("master code mishandled");
	ara_clear_a: assert property (ara_win |=> alert_clear)
		else $error("won response did not clear alert");

	write_seen_c: cover property (reg_wr_stb && reg_wr_lsb);
	read_seen_c: cover property (state_q == ST_MACK && kind_q == K_RD && idx_q == IDX_WRAP);
	ara_seen_c: cover property (ara_win);
	gc_reset_c: cover property (gc_reset);
endmodule
`default_nettype wire

// ===== verification/ssp_bus_master.sv
// Behavioural two-wire bus master that makes the clock and moves data
`timescale 1ns/1ps
`default_nettype none
module ssp_bus_master (
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda
);
	// Bus idles with both lines released to the pull-up
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// START or repeated START: data falls while the clock is high
	task automatic start();
		sda_low = 1'b0;
		#16 scl = 1'b1;
		#32 sda_low = 1'b1;
		#32 scl = 1'b0;
		#16;
	endtask

	// STOP: data rises while the clock is high, then bus free time
	task automatic stop();
		sda_low = 1'b1;
		#16 scl = 1'b1;
		#32 sda_low = 1'b0;
		#48;
	endtask

	// One clock pulse; data only moves while the clock is low
	task automatic pulse(input logic b, output logic r);
		sda_low = !b;
		#16 scl = 1'b1;
		#16 r = sda;
		#16 scl = 1'b0;
		#16;
	endtask

	// Byte out, top bit first, then the receiver's acknowledge
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			pulse(b[i], r);
		pulse(1'b1, r);
		ack = !r;
	endtask

	// Byte in, then acknowledge it or refuse it to end the read
	task automatic get(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			pulse(1'b1, b[i]);
		pulse(!ack, r);
	endtask
endmodule
`default_nettype wire

// ===== verification/sensor_i2c_slave_port_test.sv
// Self-checking bench for the sensor two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module sensor_i2c_slave_port_test;
	import ssp_pkg::*;
	logic        ref_clk;
	logic        arst_n;
	logic        scl;
	logic        m_low;
	wire  logic  sda;
	logic        sda_o;
	logic        sda_oe;
	logic [1:0]  pin_a;
	logic [1:0]  pin_b;
	logic        int_mode;
	logic        sense;
	logic        alert;
	logic        dir_low;
	logic        sd;
	logic [15:0] rd_data;
	logic [7:0]  reg_ptr;
	logic        wr_stb;
	logic [7:0]  wr_data;
	logic        wr_lsb;
	logic        rd_stb;
	logic        clr;
	logic        gc_rst;
	logic        hs;
	logic [6:0]  saddr;
	logic        apin;
	logic        apin_s;
	logic [6:0]  saddr_s;
	logic        a;
	logic [7:0]  d;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          n_clr = 0;
	int          n_gc = 0;
	int          n_rd = 0;
	int          n_wr = 0;

	// Wired-AND data line with pull-up; pointed register reflects the pointer
	assign sda = !(m_low || (sda_oe && !sda_o));
	assign rd_data = {8'hC0 | reg_ptr, 8'h5A};

	ssp_bus_master M (.scl(scl), .sda_low(m_low), .sda(sda));

	ssp_i2c_slave #(.TWO_PIN(1)) DUT (
		.ref_clk(ref_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin_a(pin_a),
		.addr_select_pin_b(pin_b), .interrupt_mode_sel(int_mode),
		.output_sense_sel(sense), .alert_active(alert), .alert_dir_low(dir_low),
		.shutdown_en(sd), .reg_rd_data(rd_data), .reg_ptr(reg_ptr),
		.reg_wr_stb(wr_stb), .reg_wr_data(wr_data), .reg_wr_lsb(wr_lsb),
		.reg_rd_stb(rd_stb), .alert_clear(clr), .gc_reset(gc_rst),
		.alert_pin(apin), .hs_mode(hs), .slave_addr(saddr)
	);

	// Single-pin variant listening on the same bus; its data output stays off the wire
	ssp_i2c_slave #(.TWO_PIN(0)) DUT_SP (
		.ref_clk(ref_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe(), .addr_select_pin_a(pin_a),
		.addr_select_pin_b(pin_b), .interrupt_mode_sel(int_mode),
		.output_sense_sel(sense), .alert_active(alert), .alert_dir_low(dir_low),
		.shutdown_en(sd), .reg_rd_data(rd_data), .reg_ptr(),
		.reg_wr_stb(), .reg_wr_data(), .reg_wr_lsb(),
		.reg_rd_stb(), .alert_clear(), .gc_reset(),
		.alert_pin(apin_s), .hs_mode(), .slave_addr(saddr_s)
	);

	// Core clock, 4 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Pulse counters for the one-cycle strobes
	always @(posedge ref_clk)
	begin
		if (clr === 1'b1)
			n_clr++;
		if (gc_rst === 1'b1)
			n_gc++;
		if (rd_stb === 1'b1)
			n_rd++;
		if (wr_stb === 1'b1)
			n_wr++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One byte from the master, compared with the expected acknowledge
	task automatic wr(input logic [7:0] b, input logic e);
		M.put(b, a);
		chk(16'(a), 16'(e));
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		#200000;
		n_mismatch++;
		test_done();
	end

	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		int_mode = 1'b0;
		sense = 1'b0;
		alert = 1'b0;
		dir_low = 1'b1;
		sd = 1'b0;
		pin_a = PIN_FLOAT;
		pin_b = PIN_LOW;
		idle(3);
		arst_n = 1'b1;
		idle(10);
		chk(16'(saddr), 16'h0049);
		chk(16'(saddr_s), 16'h0049);
		pin_a = PIN_HIGH;
		idle(10);
		chk(16'(saddr), 16'h0049);
		// Pointer then two data bytes
		M.start();
		wr(8'h92, 1'b1);
		wr(8'h03, 1'b1);
		chk(16'(reg_ptr), 16'h0003);
		wr(8'hA5, 1'b1);
		chk({wr_lsb, wr_data}, 16'h00A5);
		wr(8'h3C, 1'b1);
		chk({wr_lsb, wr_data}, 16'h013C);
		M.stop();
		chk(16'(n_wr), 16'h0002);
		// Pointer-only write, then a two-byte read
		M.start();
		wr(8'h92, 1'b1);
		wr(8'h01, 1'b1);
		M.stop();
		M.start();
		wr(8'h93, 1'b1);
		M.get(1'b1, d);
		chk(16'(d), 16'h00C1);
		M.get(1'b0, d);
		chk(16'(d), 16'h005A);
		M.stop();
		chk({7'h00, sda_oe, reg_ptr}, 16'h0001);
		chk(16'(n_rd), 16'h0001);
		chk(16'(n_clr), 16'h0000);
		// Address of the unlatched strap setting is ignored
		M.start();
		wr(8'h94, 1'b0);
		M.stop();
		// Alert response with both sense settings
		int_mode = 1'b1;
		alert = 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			sense = s[0];
			M.start();
			wr(8'h19, 1'b1);
			M.get(1'b0, d);
			chk(16'(d), {8'h00, 7'h49, dir_low ^ sense});
			chk(16'(apin_s), 16'(s));
			chk(16'(apin), 16'h0001);
			M.stop();
			chk(16'(n_clr), 16'(s + 1));
		end
		// A rival answering with a lower address wins; the alert stays pending
		M.start();
		wr(8'h19, 1'b1);
		wr(8'h00, 1'b0);
		M.stop();
		chk(16'(n_clr), 16'h0002);
		alert = 1'b0;
		M.start();
		wr(8'h19, 1'b0);
		M.stop();
		// Read and shutdown clear the alert in interrupt mode
		M.start();
		wr(8'h93, 1'b1);
		M.get(1'b0, d);
		M.stop();
		chk(16'(d), 16'h00C1);
		chk(16'(n_clr), 16'h0003);
		sd = 1'b1;
		idle(6);
		chk(16'(n_clr), 16'h0004);
		// High-speed code
		M.start();
		wr(8'h0A, 1'b0);
		chk(16'(hs), 16'h0001);
		M.stop();
		chk(16'(hs), 16'h0000);
		// General Call
		M.start();
		wr(8'h01, 1'b0);
		M.stop();
		M.start();
		wr(8'h00, 1'b1);
		wr(8'h04, 1'b1);
		M.stop();
		// Other command bytes are taken and ignored
		M.start();
		wr(8'h00, 1'b1);
		wr(8'h05, 1'b1);
		M.stop();
		idle(10);
		chk(16'(saddr), 16'h004A);
		chk(16'(saddr_s), 16'h004A);
		chk(16'(reg_ptr), 16'h0001);
		chk(16'(n_gc), 16'h0000);
		pin_b = PIN_HIGH;
		M.start();
		wr(8'h00, 1'b1);
		wr(8'h06, 1'b1);
		M.stop();
		idle(10);
		chk(16'(saddr), 16'h004E);
		chk(16'(n_gc), 16'h0001);
		chk(16'(n_clr), 16'h0005);
		chk(16'(reg_ptr), 16'h0000);
		M.start();
		wr(8'h9C, 1'b1);
		M.stop();
		test_done();
	end
endmodule
`default_nettype wire
